// ==== rtl/tdc_top.sv ====
// tdc_top: tap detection configuration, source and threshold registers
// with the tap sequencer they steer. assumes samples arrive on clk as a
// one-cycle sample_valid at the output data rate; scl/sda are pins.
`timescale 1ns/100ps
`include "tdc_defines.svh"
module tdc_top
  import tdc_pkg::*;
#(
  parameter int ACC_W = 8,
  parameter logic [6:0] SLAVE_ADDR = `TDC_I2C_ADDR_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sample_valid,
  input wire logic [2:0][ACC_W-1:0] acc,
  input wire logic [7:0] tap_latency_timer,
  input wire logic [7:0] tap_window,
  output logic tap_irq
);

  // samples scaled so one lsb equals one threshold step
  if (ACC_W < 8) begin : g_chk
    $error("ACC_W must be at least 8");
  end

  tdc_reg_if rif();
  tdc_top_state_t s, n;
  logic [2:0] above, sign, start_v;
  logic any_start, all_below, rd_src, ev_valid, ev_dbl;
  logic [2:0] ev_axes, ev_mask;

  tdc_i2c_slave #(.SLAVE_ADDR(SLAVE_ADDR)) u_i2c (
    .clk(clk),
    .rst_n(rst_n),
    .scl(scl),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .bus(rif.master)
  );

  assign sda_out = 1'b0; // open drain: only the enable moves
  assign tap_irq = s.src[`TDC_SRC_ACTIVE];

  // magnitude of a signed sample
  function automatic logic [ACC_W-1:0] mag(input logic [ACC_W-1:0] a);
    return a[ACC_W-1] ? ACC_W'(-a) : a;
  endfunction

  // enable mask for one tap type out of tap_config
  function automatic logic [2:0] type_en(input logic [7:0] cfg, input logic dbl);
    return {cfg[4 + 32'(dbl)], cfg[2 + 32'(dbl)], cfg[`TDC_CFG_XS + 32'(dbl)]};
  endfunction

  // per-axis threshold compare; unsigned steps, fixed range
  for (genvar i = 0; i < 3; i++) begin : g_axis
    assign above[i] = mag(acc[i]) > ACC_W'(s.thr[i]);
    assign sign[i] = acc[i][ACC_W-1];
    assign start_v[i] = above[i] & ~s.above_prev[i];
  end
  assign any_start = |start_v;
  assign all_below = ~|above;
  assign rd_src = rif.rd && (rif.addr == `TDC_OFS_SRC);

  // register read mux; thresholds pad bit 7 with zero
  always_comb begin
    case (rif.addr)
      `TDC_OFS_CFG: rif.rdata = s.cfg;
      `TDC_OFS_SRC: rif.rdata = s.src;
      `TDC_OFS_THX: rif.rdata = {1'b0, s.thr[0]};
      `TDC_OFS_THY: rif.rdata = {1'b0, s.thr[1]};
      `TDC_OFS_THZ: rif.rdata = {1'b0, s.thr[2]};
      default: rif.rdata = 8'h00;
    endcase
  end

  // tap sequencer, registers and source update
  always_comb begin
    n = s;
    ev_valid = 1'b0;
    ev_dbl = 1'b0;
    ev_axes = 3'h0;
    // host writes; source is read-only so it has no write branch
    if (rif.wr) begin
      case (rif.addr)
        `TDC_OFS_CFG: n.cfg = rif.wdata;
        `TDC_OFS_THX: n.thr[0] = rif.wdata[6:0];
        `TDC_OFS_THY: n.thr[1] = rif.wdata[6:0];
        `TDC_OFS_THZ: n.thr[2] = rif.wdata[6:0];
        default: begin
        end
      endcase
    end
    if (sample_valid) begin
      n.above_prev = above;
      case (s.dstate)
        TDC_IDLE: begin
          if (any_start) begin
            ev_valid = 1'b1;
            ev_axes = start_v;
            n.lcnt = tap_latency_timer;
            n.started = 1'b0;
            n.aborted = 1'b0;
            n.dstate = TDC_LAT;
          end
        end
        TDC_LAT: begin
          // taps here never report; they only feed the abort check
          if (any_start) begin
            n.started = 1'b1;
          end
          if (s.started && all_below && s.cfg[`TDC_CFG_ABORT]) begin
            n.aborted = 1'b1;
          end
          if (s.lcnt == 8'h00) begin
            n.wcnt = tap_window;
            n.dstate = n.aborted ? TDC_IDLE : TDC_WIN;
          end else begin
            n.lcnt = s.lcnt - 8'h01;
          end
        end
        TDC_WIN: begin
          if (any_start) begin
            ev_valid = 1'b1;
            ev_dbl = 1'b1;
            ev_axes = start_v;
            n.dstate = TDC_IDLE;
          end else if (s.wcnt == 8'h00) begin
            n.dstate = TDC_IDLE;
          end else begin
            n.wcnt = s.wcnt - 8'h01;
          end
        end
        default: n.dstate = TDC_IDLE;
      endcase
    end
    ev_mask = ev_axes & type_en(s.cfg, ev_dbl);
    // read clears first so a same-cycle event still lands
    if (rd_src) begin
      n.src = `TDC_RST_SRC;
    end
    if (s.cfg[`TDC_CFG_LATCH]) begin
      // latched: first event wins until the host reads
      if (ev_valid && (|ev_mask) && !n.src[`TDC_SRC_ACTIVE]) begin
        n.src = {1'b1, ev_mask, ev_dbl, sign & ev_mask};
      end
    end else if (sample_valid) begin
      // unlatched: source mirrors the latest sample only
      n.src = (ev_valid && (|ev_mask)) ? {1'b1, ev_mask, ev_dbl, sign & ev_mask}
                                        : `TDC_RST_SRC;
    end
  end

  // single state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{cfg: `TDC_RST_CFG, thr: {3{`TDC_RST_THR}}, src: `TDC_RST_SRC,
             dstate: TDC_IDLE, lcnt: 8'h00, wcnt: 8'h00, started: 1'b0,
             aborted: 1'b0, above_prev: 3'h0};
    end else begin
      s <= n;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_cfg_write_lands: assert property (
    rif.wr && rif.addr == `TDC_OFS_CFG |=> s.cfg == $past(rif.wdata))
    else $error("config write not stored");

  a_no_abort_clear: assert property (
    s.dstate == TDC_LAT && !s.cfg[`TDC_CFG_ABORT] && !s.aborted |=> !s.aborted)
    else $error("abort raised while abort disabled");

  a_abort_to_idle: assert property (
    sample_valid && s.dstate == TDC_LAT && s.aborted && s.lcnt == 8'h00
    |=> s.dstate == TDC_IDLE)
    else $error("aborted latency did not return to idle");

  a_unlatched_clears: assert property (
    !s.cfg[`TDC_CFG_LATCH] && sample_valid && !ev_valid |=> s.src == 8'h00)
    else $error("unlatched source held a stale event");

  a_flag_tracks_axes: assert property (
    s.src[`TDC_SRC_ACTIVE] == (|s.src[6:4]))
    else $error("event flag disagrees with axis bits");

  a_sign_masked: assert property (
    (s.src[2:0] & ~s.src[6:4]) == 3'h0)
    else $error("sign reported on an axis without event");

  a_enable_gates: assert property (
    $rose(s.src[`TDC_SRC_ACTIVE]) |->
      (s.src[6:4] & ~type_en($past(s.cfg), s.src[`TDC_SRC_DBL])) == 3'h0)
    else $error("disabled tap reached source");

  a_latch_freeze: assert property (
    s.cfg[`TDC_CFG_LATCH] && s.src[`TDC_SRC_ACTIVE] && !rd_src ##1 s.cfg[`TDC_CFG_LATCH]
    |-> $stable(s.src))
    else $error("latched source changed before read");

  a_read_clears: assert property (
    rd_src && !ev_valid |=> s.src == 8'h00 && !tap_irq)
    else $error("source read did not clear");

  a_thr_bit7_zero: assert property (
    rif.addr inside {`TDC_OFS_THX, `TDC_OFS_THY, `TDC_OFS_THZ} |-> !rif.rdata[7])
    else $error("threshold bit 7 not zero");

  a_latency_silent: assert property (
    s.dstate == TDC_LAT |-> !ev_valid)
    else $error("tap reported during latency");

  a_src_write_ignored: assert property (
    rif.wr && rif.addr == `TDC_OFS_SRC && !sample_valid && !rd_src |=> $stable(s.src))
    else $error("write changed source register");

  c_single_tap: cover property ($rose(s.src[`TDC_SRC_ACTIVE]) && !s.src[`TDC_SRC_DBL]);
  c_double_tap: cover property ($rose(s.src[`TDC_SRC_ACTIVE]) && s.src[`TDC_SRC_DBL]);
  c_abort_taken: cover property (s.dstate == TDC_LAT ##1 s.aborted);
  c_read_clear: cover property (rd_src && s.src[`TDC_SRC_ACTIVE]);

endmodule

// ==== rtl/tdc_defines.svh ====
// tdc_defines.svh: register offsets, field positions, reset values
// assumes inclusion by bare name from any tdc design file
`ifndef TDC_DEFINES_SVH
`define TDC_DEFINES_SVH

// register offsets on the serial register interface
`define TDC_OFS_CFG 8'h21
`define TDC_OFS_SRC 8'h22
`define TDC_OFS_THX 8'h23
`define TDC_OFS_THY 8'h24
`define TDC_OFS_THZ 8'h25

// tap_config field positions
`define TDC_CFG_ABORT 7
`define TDC_CFG_LATCH 6
`define TDC_CFG_XS 0

// tap_source field positions
`define TDC_SRC_ACTIVE 7
`define TDC_SRC_AX_LO 4
`define TDC_SRC_DBL 3

// reset values
`define TDC_RST_CFG 8'h00
`define TDC_RST_SRC 8'h00
`define TDC_RST_THR 7'h00

// serial slave address default, arbitrary value
`define TDC_I2C_ADDR_DEF 7'h3A

`endif

// ==== rtl/tdc_pkg.sv ====
// tdc_pkg: state types of the tap detection register block
// assumes nothing beyond a SystemVerilog compiler
package tdc_pkg;

  typedef enum logic [1:0] {TDC_IDLE, TDC_LAT, TDC_WIN} tdc_det_t;

  typedef enum logic [3:0] {
    TDC_I_IDLE, TDC_I_ADDR, TDC_I_ADDR_ACK, TDC_I_REG, TDC_I_REG_ACK,
    TDC_I_WDATA, TDC_I_WDATA_ACK, TDC_I_RDATA, TDC_I_RDATA_ACK
  } tdc_i2c_st_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [2:0][6:0] thr;
    logic [7:0] src;
    tdc_det_t dstate;
    logic [7:0] lcnt;
    logic [7:0] wcnt;
    logic started;
    logic aborted;
    logic [2:0] above_prev;
  } tdc_top_state_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    tdc_i2c_st_t st;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic rw;
    logic more;
    logic [7:0] ptr;
    logic oe;
  } tdc_i2c_state_t;

endpackage

// ==== rtl/tdc_reg_if.sv ====
// tdc_reg_if: register access strobes between serial slave and bank
// assumes both ends on the same clock
`timescale 1ns/100ps
interface tdc_reg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport master (output addr, output wdata, output wr, output rd, input rdata);
  modport slave (input addr, input wdata, input wr, input rd, output rdata);
endinterface

// ==== rtl/tdc_i2c_slave.sv ====
// tdc_i2c_slave: serial register interface slave, auto-incrementing pointer
// assumes scl and sda come from pins; both are synchronised here
`timescale 1ns/100ps
`include "tdc_defines.svh"
module tdc_i2c_slave
  import tdc_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `TDC_I2C_ADDR_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe,
  tdc_reg_if.master bus
);

  tdc_i2c_state_t s, n;
  logic rise, fall, start, stop;

  // edges taken only from the second sync stage and its delayed copy
  assign rise = s.scl_s2 & ~s.scl_d;
  assign fall = ~s.scl_s2 & s.scl_d;
  assign start = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
  assign stop = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;
  assign sda_oe = s.oe;
  assign bus.addr = s.ptr;
  assign bus.wdata = s.shift;

  // protocol engine
  always_comb begin
    n = s;
    bus.wr = 1'b0;
    bus.rd = 1'b0;
    n.scl_s1 = scl;
    n.scl_s2 = s.scl_s1;
    n.scl_d = s.scl_s2;
    n.sda_s1 = sda_in;
    n.sda_s2 = s.sda_s1;
    n.sda_d = s.sda_s2;
    if (start) begin
      n.st = TDC_I_ADDR;
      n.bitcnt = 4'h0;
      n.oe = 1'b0;
    end else if (stop) begin
      n.st = TDC_I_IDLE;
      n.oe = 1'b0;
    end else if (rise) begin
      case (s.st)
        TDC_I_ADDR, TDC_I_REG, TDC_I_WDATA: begin
          n.shift = {s.shift[6:0], s.sda_s2};
          n.bitcnt = s.bitcnt + 4'h1;
        end
        TDC_I_RDATA_ACK: begin
          // master nack ends the read burst
          if (s.sda_s2) begin
            n.st = TDC_I_IDLE;
          end else begin
            n.more = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      case (s.st)
        TDC_I_ADDR: begin
          if (s.bitcnt == 4'h8) begin
            if (s.shift[7:1] == SLAVE_ADDR) begin
              n.oe = 1'b1;
              n.rw = s.shift[0];
              n.st = TDC_I_ADDR_ACK;
            end else begin
              n.st = TDC_I_IDLE;
            end
          end
        end
        TDC_I_ADDR_ACK: begin
          n.bitcnt = 4'h0;
          if (s.rw) begin
            bus.rd = 1'b1;
            n.shift = bus.rdata;
            n.oe = ~bus.rdata[7];
            n.st = TDC_I_RDATA;
          end else begin
            n.oe = 1'b0;
            n.st = TDC_I_REG;
          end
        end
        TDC_I_REG: begin
          if (s.bitcnt == 4'h8) begin
            n.ptr = s.shift;
            n.oe = 1'b1;
            n.st = TDC_I_REG_ACK;
          end
        end
        TDC_I_WDATA: begin
          if (s.bitcnt == 4'h8) begin
            bus.wr = 1'b1;
            n.oe = 1'b1;
            n.st = TDC_I_WDATA_ACK;
          end
        end
        TDC_I_REG_ACK, TDC_I_WDATA_ACK: begin
          if (s.st == TDC_I_WDATA_ACK) begin
            n.ptr = s.ptr + 8'h01;
          end
          n.oe = 1'b0;
          n.bitcnt = 4'h0;
          n.st = TDC_I_WDATA;
        end
        TDC_I_RDATA: begin
          if (s.bitcnt == 4'h7) begin
            n.oe = 1'b0;
            n.more = 1'b0;
            n.ptr = s.ptr + 8'h01;
            n.st = TDC_I_RDATA_ACK;
          end else begin
            n.shift = {s.shift[6:0], 1'b0};
            n.oe = ~s.shift[6];
            n.bitcnt = s.bitcnt + 4'h1;
          end
        end
        TDC_I_RDATA_ACK: begin
          // acked: fetch next byte; its read strobe, like the one in TDC_I_ADDR_ACK, clears the source when ptr is on it
          if (s.more) begin
            bus.rd = 1'b1;
            n.shift = bus.rdata;
            n.oe = ~bus.rdata[7];
            n.bitcnt = 4'h0;
            n.st = TDC_I_RDATA;
          end
        end
        default: begin
          n.st = TDC_I_IDLE;
        end
      endcase
    end
  end

  // state register, sync stages reset high like an idle bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
             sda_d: 1'b1, st: TDC_I_IDLE, shift: 8'h00, bitcnt: 4'h0, rw: 1'b0,
             more: 1'b0, ptr: 8'h00, oe: 1'b0};
    end else begin
      s <= n;
    end
  end

endmodule

// ==== verif/tdc_host_model.sv ====
// tdc_host_model: host side of the serial register interface
// assumes a pull-up on sda; clk only paces the 800 ns serial clock
`timescale 1ns/100ps
module tdc_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h3A
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // quarter bit of two clk keeps scl high and low for four clk each
  task automatic q();
    repeat (2) @(posedge clk);
  endtask

  // one bit: line set while scl is low, sampled mid-high
  task automatic bit_io(input logic drive_low, output logic seen);
    sda_oe <= drive_low;
    q();
    scl <= 1'b1;
    q();
    seen = sda;
    q();
    scl <= 1'b0;
    q();
  endtask

  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_oe <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask

  task automatic stop();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b0;
    q();
    q();
  endtask

  // msb first, then the device's acknowledge slot with sda released
  task automatic put_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(~b[i], s);
    end
    bit_io(1'b0, s);
  endtask

  // last byte of a read: master answers with a nack
  task automatic get_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b0, d[i]);
    end
    bit_io(1'b0, s);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    start();
    put_byte({DEV_ADDR, 1'b0});
    put_byte(a);
    put_byte(d);
    stop();
  endtask

  // pointer write, then repeated start and one read byte
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    start();
    put_byte({DEV_ADDR, 1'b0});
    put_byte(a);
    start();
    put_byte({DEV_ADDR, 1'b1});
    get_byte(d);
    stop();
  endtask
endmodule

// ==== verif/tb_top.sv ====
// tb_top: self-checking bench for the tap detection register block
// assumes tdc_host_model as bus master and a pull-up on sda
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, m_oe, sda_oe, sda_out, tap_irq;
  logic sample_valid = 1'b0;
  logic [2:0][7:0] acc = '0;
  logic [7:0] ltcy = 8'h03;
  logic [7:0] wind = 8'h03;
  logic [7:0] rd, r, tv, mag;
  logic [7:0] th [3];
  logic [2:0] axes, neg;
  logic [2:0][7:0] smp_v;
  int bad_count = 0;
  int samples_checked = 0;
  wire logic sda_w;

  // open-drain wire: low while either side pulls
  assign sda_w = ~(sda_oe | m_oe);

  always #50 clk = ~clk;

  tdc_top dut_u (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .sample_valid(sample_valid), .acc(acc), .tap_latency_timer(ltcy),
    .tap_window(wind), .tap_irq(tap_irq));
  tdc_host_model host_u (.clk(clk), .sda(sda_w), .scl(scl), .sda_oe(m_oe));

  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd_reg(a, rd);
    chk(rd, exp);
  endtask

  // irq is looked at mid-cycle, after the edge's updates have landed
  task automatic chk_irq(input logic exp);
    @(negedge clk);
    chk({7'h00, tap_irq}, {7'h00, exp});
  endtask

  // one output data sample, valid for a single clk
  task automatic smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    @(posedge clk);
    acc <= {z, y, x};
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
  endtask

  // long enough for latency and window to run out at 3 and 3
  task automatic quiet(input int n);
    repeat (n) smp(8'h00, 8'h00, 8'h00);
  endtask

  function automatic logic [7:0] src_exp(input logic [2:0] ax, input logic dbl,
    input logic [2:0] ng);
    return {1'b1, ax, dbl, ax & ng};
  endfunction

  initial begin
    void'($urandom(29));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // reset values, one unmapped offset among them
    for (int a = 8'h21; a <= 8'h26; a++) rd_chk(8'(a), 8'h00);
    chk_irq(1'b0);
    chk({7'h00, sda_out}, 8'h00);
    r = 8'($urandom);
    host_u.wr_reg(8'h21, r);
    rd_chk(8'h21, r);
    for (int i = 0; i < 3; i++) begin
      th[i] = 8'($urandom_range(10, 60)) | 8'h80;
      host_u.wr_reg(8'(8'h23 + i), th[i]);
      th[i][7] = 1'b0;
    end
    for (int i = 0; i < 3; i++) rd_chk(8'(8'h23 + i), th[i]);
    // latched single taps on random axes and signs
    host_u.wr_reg(8'h21, 8'h55);
    for (int k = 0; k < 6; k++) begin
      axes = 3'($urandom_range(1, 7));
      neg = 3'($urandom);
      for (int i = 0; i < 3; i++) begin
        mag = th[i] + 8'($urandom_range(1, 20));
        smp_v[i] = axes[i] ? (neg[i] ? 8'(-mag) : mag) : th[i];
      end
      smp(smp_v[0], smp_v[1], smp_v[2]);
      quiet(10);
      chk_irq(1'b1);
      rd_chk(8'h22, src_exp(axes, 1'b0, neg));
      chk_irq(1'b0);
      rd_chk(8'h22, 8'h00);
    end
    // second event held off by the first; writes to source ignored
    smp(th[0] + 8'h05, 8'h00, 8'h00);
    quiet(10);
    smp(8'h00, 8'(-(th[1] + 8'h05)), 8'h00);
    quiet(10);
    host_u.wr_reg(8'h22, 8'hFF);
    chk_irq(1'b1);
    rd_chk(8'h22, 8'h90);
    // latch off: flags follow only the latest sample
    host_u.wr_reg(8'h21, 8'h15);
    smp(8'h00, 8'h00, 8'(-(th[2] + 8'h05)));
    chk_irq(1'b1);
    smp(8'h00, 8'h00, 8'h00);
    chk_irq(1'b0);
    rd_chk(8'h22, 8'h00);
    quiet(10);
    // double tap on x: plain, aborted by a short tap, late tap missing
    tv = th[0] + 8'h08;
    for (int k = 0; k < 3; k++) begin
      host_u.wr_reg(8'h21, (k == 1) ? 8'hC2 : 8'h42);
      smp(tv, 8'h00, 8'h00);
      quiet(1);
      smp(tv, 8'h00, 8'h00);
      quiet(3);
      if (k != 2) smp(tv, 8'h00, 8'h00);
      quiet(10);
      rd_chk(8'h22, (k == 0) ? 8'h98 : 8'h00);
    end
    stop_test();
  end

  // watchdog: roughly five times the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    stop_test();
  end
endmodule
